// ==== design/srw_pkg.sv ====
package srw_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned HOLD_MS_00 = 50;
  localparam int unsigned HOLD_MS_01 = 200;
  localparam int unsigned HOLD_MS_10 = 400;
  localparam int unsigned HOLD_MS_11 = 800;
  localparam int unsigned WDOG_MS_00 = 1400;
  localparam int unsigned WDOG_MS_01 = 200;
  localparam int unsigned WDOG_MS_10 = 25;
  localparam int unsigned CYC_PER_MS = CLK_MHZ * 1000;
  localparam int unsigned DEBOUNCE_US = 10;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
  localparam int unsigned CNT_W = 32;
  // ----------------------------------------
  // APB register map
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;
  // Control layout: hold select, watchdog select
  localparam int unsigned CTRL_HOLD_LSB = 0;
  localparam int unsigned CTRL_WDOG_LSB = 2;
  localparam logic [1:0] HOLD_SEL_RST = 2'h1;
  localparam logic [1:0] WDOG_SEL_RST = 2'h3;
  localparam logic [1:0] WDOG_OFF = 2'h3;
  // Event bits: reset, low supply, fail2, fail3, timeout
  localparam int unsigned EV_W = 5;
  localparam int unsigned EV_RST = 0;
  localparam int unsigned EV_LOW = 1;
  localparam int unsigned EV_F2 = 2;
  localparam int unsigned EV_F3 = 3;
  localparam int unsigned EV_WDT = 4;
endpackage : srw_pkg

// ==== design/srw_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module srw_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= RST_VAL;
      dout <= RST_VAL;
    end
    else
    begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule : srw_sync
`default_nettype wire

// ==== design/srw_top.sv ====
// Contract
// R1: Write-protect high refuses every register write.
// R2: Third fail output low while third voltage under threshold, no delay.
// R3: Watchdog timeout output active low on expiry without restart.
// R4: Reset held at power-on until supply good for hold time.
// R5: Manual reset holds reset, then a further hold time after release.
// R6: Supply drop asserts reset until good for hold time.
// R7: Second fail output asserted while second voltage under threshold.
// R8: Early low output follows primary supply without hold delay.
// R9: Any bus read or write sequence restarts the watchdog.
// R10: Start, clock low, clock high, stop is minimum restart sequence.
// R11: Two control bits select watchdog period; host may change them.
// R12: Period codes 1.4s, 200ms, 25ms, disabled (default 11).
// R13: Hold codes 50ms, 200ms default, 400ms, 800ms.
// R14: Data fall during clock fall then stop restarts watchdog; code needs data fall while clock high, then a clock fall, then stop.
// R15: Comparators and manual reset synchronised; manual reset debounced.
// R16: Counters on internal clock restart when condition lost.
`timescale 1ns/1ps
`default_nettype none
module srw_top #(
  parameter int unsigned HOLD_CYC_00 = srw_pkg::HOLD_MS_00 * srw_pkg::CYC_PER_MS,
  parameter int unsigned HOLD_CYC_01 = srw_pkg::HOLD_MS_01 * srw_pkg::CYC_PER_MS,
  parameter int unsigned HOLD_CYC_10 = srw_pkg::HOLD_MS_10 * srw_pkg::CYC_PER_MS,
  parameter int unsigned HOLD_CYC_11 = srw_pkg::HOLD_MS_11 * srw_pkg::CYC_PER_MS,
  parameter int unsigned WDOG_CYC_00 = srw_pkg::WDOG_MS_00 * srw_pkg::CYC_PER_MS,
  parameter int unsigned WDOG_CYC_01 = srw_pkg::WDOG_MS_01 * srw_pkg::CYC_PER_MS,
  parameter int unsigned WDOG_CYC_10 = srw_pkg::WDOG_MS_10 * srw_pkg::CYC_PER_MS,
  parameter int unsigned DEB_CYC = srw_pkg::DEBOUNCE_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic write_protect_in,
  input wire logic primary_above_in,
  input wire logic second_above_in,
  input wire logic third_above_in,
  input wire logic manual_reset_in_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic system_reset_out,
  output logic early_low_supply_out_n,
  output logic second_fail_out_n,
  output logic third_fail_out_n,
  output logic watchdog_timeout_out_n,
  output logic irq
);
  localparam int unsigned CW = srw_pkg::CNT_W;
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Idle levels: manual reset and bus lines high, no false edge after reset
  localparam logic [5:0] SYNC_IDLE = 6'h07;
  logic [5:0] sync_s;
  logic pri_s, sec_s, thr_s, mr_raw_s, scl_s, sda_s;
  // R15: sync inputs
  srw_sync #(.W(6), .RST_VAL(SYNC_IDLE)) u_sync (
    .clk(clk),
    .rst(rst),
    .din({primary_above_in, second_above_in, third_above_in, manual_reset_in_n,
          scl_in, sda_in}),
    .dout(sync_s)
  );
  assign {pri_s, sec_s, thr_s, mr_raw_s, scl_s, sda_s} = sync_s;

  // ----------------------------------------
  // Manual reset debounce
  // ----------------------------------------
  logic mr_n_q;
  logic [CW-1:0] deb_q;
  // R15: debounce
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mr_n_q <= 1'b1;
      deb_q <= '0;
    end
    else if (mr_raw_s == mr_n_q)
      deb_q <= '0;
    else if (deb_q >= DEB_CYC - 1)
    begin
      mr_n_q <= mr_raw_s;
      deb_q <= '0;
    end
    else
      deb_q <= deb_q + 1'b1;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [1:0] hold_sel_q, wdog_sel_q;
  logic [srw_pkg::EV_W-1:0] ev_stat_q, ev_mask_q, ev_set;
  logic wr_en, rd_en;
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pslverr = psel && penable && (paddr != srw_pkg::CTRL_OFS)
    && (paddr != srw_pkg::STAT_OFS) && (paddr != srw_pkg::IRQ_STAT_OFS)
    && (paddr != srw_pkg::IRQ_MASK_OFS);

  // R11: selects writable by host
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hold_sel_q <= srw_pkg::HOLD_SEL_RST;
      wdog_sel_q <= srw_pkg::WDOG_SEL_RST;
      ev_mask_q <= '0;
    end
    // R1: write protect
    else if (wr_en && !write_protect_in)
    begin
      if (paddr == srw_pkg::CTRL_OFS)
      begin
        hold_sel_q <= pwdata[srw_pkg::CTRL_HOLD_LSB +: 2];
        wdog_sel_q <= pwdata[srw_pkg::CTRL_WDOG_LSB +: 2];
      end
      if (paddr == srw_pkg::IRQ_MASK_OFS)
        ev_mask_q <= pwdata[srw_pkg::EV_W-1:0];
    end
  end

  // Sticky events; set wins over clear
  always_ff @(posedge clk)
  begin
    if (rst)
      ev_stat_q <= '0;
    else if (wr_en && !write_protect_in && paddr == srw_pkg::IRQ_STAT_OFS)
      ev_stat_q <= (ev_stat_q & ~pwdata[srw_pkg::EV_W-1:0]) | ev_set;
    else
      ev_stat_q <= ev_stat_q | ev_set;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(ev_stat_q & ev_mask_q);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      prdata <= '0;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        srw_pkg::CTRL_OFS: prdata <= {28'h0, wdog_sel_q, hold_sel_q};
        srw_pkg::STAT_OFS: prdata <= {26'h0, write_protect_in, !watchdog_timeout_out_n,
          !third_fail_out_n, !second_fail_out_n, !early_low_supply_out_n, system_reset_out};
        srw_pkg::IRQ_STAT_OFS: prdata <= {27'h0, ev_stat_q};
        srw_pkg::IRQ_MASK_OFS: prdata <= {27'h0, ev_mask_q};
        default: prdata <= '0;
      endcase
    end
  end

  // ----------------------------------------
  // Reset hold
  // ----------------------------------------
  logic [CW-1:0] hold_q, hold_lim;
  logic rst_cond;
  // R13: hold encoding
  always_comb
  begin
    case (hold_sel_q)
      2'h0: hold_lim = CW'(HOLD_CYC_00);
      2'h1: hold_lim = CW'(HOLD_CYC_01);
      2'h2: hold_lim = CW'(HOLD_CYC_10);
      default: hold_lim = CW'(HOLD_CYC_11);
    endcase
  end
  assign rst_cond = !pri_s || !mr_n_q;

  // R4: power-on hold
  // R5: manual reset hold
  // R6: supply drop hold
  // R16: restart when lost
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hold_q <= '0;
      system_reset_out <= 1'b1;
    end
    else if (rst_cond)
    begin
      hold_q <= '0;
      system_reset_out <= 1'b1;
    end
    else if (system_reset_out)
    begin
      if (hold_q >= hold_lim - 1'b1)
        system_reset_out <= 1'b0;
      else
        hold_q <= hold_q + 1'b1;
    end
    else
      hold_q <= '0;
  end

  // ----------------------------------------
  // Direct monitor outputs
  // ----------------------------------------
  // R2: third fail
  // R7: second fail
  // R8: early low
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      early_low_supply_out_n <= 1'b0;
      second_fail_out_n <= 1'b0;
      third_fail_out_n <= 1'b0;
    end
    else
    begin
      early_low_supply_out_n <= pri_s;
      second_fail_out_n <= sec_s;
      third_fail_out_n <= thr_s;
    end
  end

  // ----------------------------------------
  // Bus activity detect
  // ----------------------------------------
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_STARTED = 3'b010,
    BUS_CLOCKED = 3'b100
  } srw_bus_t;
  srw_bus_t bus_q;
  logic scl_q, sda_q, start_ev, stop_ev, kick;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end
  assign start_ev = scl_s && scl_q && sda_q && !sda_s;
  assign stop_ev = scl_s && scl_q && !sda_q && sda_s;

  // R9: any transfer
  // R10: minimum sequence
  // R14: start, clock, stop
  always_ff @(posedge clk)
  begin
    if (rst)
      bus_q <= BUS_IDLE;
    else
    begin
      case (bus_q)
        BUS_IDLE: if (start_ev) bus_q <= BUS_STARTED;
        BUS_STARTED: if (scl_q && !scl_s) bus_q <= BUS_CLOCKED;
        BUS_CLOCKED:
        begin
          if (stop_ev)
            bus_q <= BUS_IDLE;
          else if (start_ev)
            bus_q <= BUS_STARTED;
        end
        default: bus_q <= BUS_IDLE;
      endcase
    end
  end
  assign kick = (bus_q == BUS_CLOCKED) && stop_ev;

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  logic [CW-1:0] wd_q, wd_lim;
  // R12: period encoding
  always_comb
  begin
    case (wdog_sel_q)
      2'h0: wd_lim = CW'(WDOG_CYC_00);
      2'h1: wd_lim = CW'(WDOG_CYC_01);
      default: wd_lim = CW'(WDOG_CYC_10);
    endcase
  end

  // R3: timeout output
  // R16: restart on kick
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wd_q <= '0;
      watchdog_timeout_out_n <= 1'b1;
    end
    else if (kick || wdog_sel_q == srw_pkg::WDOG_OFF || system_reset_out)
    begin
      wd_q <= '0;
      watchdog_timeout_out_n <= 1'b1;
    end
    else if (wd_q >= wd_lim - 1'b1)
      watchdog_timeout_out_n <= 1'b0;
    else
      wd_q <= wd_q + 1'b1;
  end

  always_comb
  begin
    ev_set = '0;
    ev_set[srw_pkg::EV_RST] = rst_cond && !system_reset_out;
    ev_set[srw_pkg::EV_LOW] = !pri_s && early_low_supply_out_n;
    ev_set[srw_pkg::EV_F2] = !sec_s && second_fail_out_n;
    ev_set[srw_pkg::EV_F3] = !thr_s && third_fail_out_n;
    ev_set[srw_pkg::EV_WDT] = (wd_q >= wd_lim - 1'b1) && watchdog_timeout_out_n
      && !kick && wdog_sel_q != srw_pkg::WDOG_OFF && !system_reset_out;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_wp_blocks_ctrl: assert property ( // R1
    wr_en && write_protect_in |=> $stable(hold_sel_q) && $stable(wdog_sel_q))
    else $error("write accepted under write protect");
  chk_third_follow: assert property ( // R2
    third_fail_out_n == $past(thr_s)) else $error("third fail lag wrong");
  chk_second_follow: assert property ( // R7
    !sec_s |=> !second_fail_out_n) else $error("second fail not asserted");
  chk_early_low: assert property ( // R8
    !pri_s |=> !early_low_supply_out_n) else $error("early low missed");
  chk_reset_on_drop: assert property ( // R6
    !pri_s |=> system_reset_out) else $error("reset not asserted on drop");
  chk_manual_hold: assert property ( // R5
    !mr_n_q |=> system_reset_out) else $error("manual reset not held");
  chk_release_hold: assert property ( // R4
    $fell(system_reset_out) |-> hold_q >= hold_lim - 1'b1 && !$past(rst_cond))
    else $error("reset released early");
  chk_kick_clears: assert property ( // R9
    kick |=> watchdog_timeout_out_n && wd_q == '0) else $error("kick ignored");
  chk_wdog_off: assert property ( // R12
    wdog_sel_q == srw_pkg::WDOG_OFF |=> watchdog_timeout_out_n)
    else $error("disabled watchdog fired");
  chk_timeout_fires: assert property ( // R3
    $fell(watchdog_timeout_out_n) |-> $past(wd_q) >= wd_lim - 1'b1)
    else $error("timeout without expiry");
  cov_kick: cover property (kick);
  cov_timeout: cover property ($fell(watchdog_timeout_out_n));
  cov_release: cover property ($fell(system_reset_out));
  cov_irq: cover property ($rose(irq));
endmodule : srw_top
`default_nettype wire

// ==== tb/srw_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module srw_host_model (
  output logic scl,
  output logic sda
);
  // ------------------------------
  // Two-wire host, pulled-up idle
  // ------------------------------
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic kick();
    #1 sda = 1'b0;
    #62.5 scl = 1'b0;
    #62.5 scl = 1'b1;
    #62.5 sda = 1'b1;
    #62.5;
  endtask : kick
endmodule : srw_host_model
`default_nettype wire

// ==== tb/srw_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module srw_top_tb;
  localparam int HC [4] = '{200, 300, 400, 500};
  localparam int WC [3] = '{1000, 600, 300};
  localparam int DEB = 4;
  logic clk, rst, psel, penable, pwrite, wp, pa, sa, ta, mr_n, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, rnd;
  logic pready, pslverr, sys_rst, low_n, f2_n, f3_n, wdo_n, irq, scl, sda;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  int m_ctrl;
  srw_top #(.HOLD_CYC_00(HC[0]), .HOLD_CYC_01(HC[1]), .HOLD_CYC_10(HC[2]),
    .HOLD_CYC_11(HC[3]), .WDOG_CYC_00(WC[0]), .WDOG_CYC_01(WC[1]), .WDOG_CYC_10(WC[2]),
    .DEB_CYC(DEB)) DUT (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .write_protect_in(wp), .primary_above_in(pa), .second_above_in(sa),
    .third_above_in(ta), .manual_reset_in_n(mr_n), .scl_in(scl), .sda_in(sda),
    .system_reset_out(sys_rst), .early_low_supply_out_n(low_n), .second_fail_out_n(f2_n),
    .third_fail_out_n(f3_n), .watchdog_timeout_out_n(wdo_n), .irq(irq));
  srw_host_model host (.scl(scl), .sda(sda));
  // ------------------------------
  // Clock, timeout, helpers
  // ------------------------------
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic meas(input logic wd, output int k);
    k = 0;
    while ((wd ? wdo_n : sys_rst) !== 1'b0 && k < 3000)
    begin
      @(negedge clk);
      k++;
    end
  endtask : meas
  function automatic logic [31:0] win(input int k, input int lo);
    return {31'h0, (k + 8 >= lo) && (k <= lo + 16)};
  endfunction : win
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial
  begin
    {rst, pa, sa, ta, mr_n} = 5'h1F;
    {psel, penable, pwrite, wp} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    m_ctrl = 32'hD;
    void'($urandom(32'h480B));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    meas(1'b0, n);
    chk(win(n, HC[1]), 32'h1);
    apb(1'b0, srw_pkg::CTRL_OFS, 32'h0);
    chk(rd & 32'hF, m_ctrl);
    apb(1'b0, 8'h10, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    wp <= 1'b1;
    apb(1'b1, srw_pkg::CTRL_OFS, 32'h0);
    wp <= 1'b0;
    apb(1'b0, srw_pkg::CTRL_OFS, 32'h0);
    chk(rd & 32'hF, m_ctrl);
    for (int i = 0; i < 4; i++)
    begin
      m_ctrl = (m_ctrl & 32'hC) | i;
      apb(1'b1, srw_pkg::CTRL_OFS, m_ctrl);
      apb(1'b1, srw_pkg::IRQ_STAT_OFS, 32'h1F);
      pa <= 1'b0;
      repeat (4 + $urandom_range(20)) @(negedge clk);
      chk({low_n, sys_rst}, 32'h1);
      apb(1'b0, srw_pkg::STAT_OFS, 32'h0);
      chk(rd, 32'h3);
      @(posedge clk);
      pa <= 1'b1;
      repeat (5) @(negedge clk);
      chk({low_n, sys_rst}, 32'h3);
      meas(1'b0, n);
      chk(win(n + 5, HC[i]), 32'h1);
      apb(1'b0, srw_pkg::IRQ_STAT_OFS, 32'h0);
      chk(rd & 32'h1F, 32'h3);
    end
    rnd = $urandom;
    apb(1'b1, srw_pkg::IRQ_MASK_OFS, rnd);
    apb(1'b0, srw_pkg::IRQ_MASK_OFS, 32'h0);
    chk(rd & 32'h1F, rnd & 32'h1F);
    apb(1'b1, srw_pkg::IRQ_MASK_OFS, 32'h1 << srw_pkg::EV_F2);
    apb(1'b1, srw_pkg::IRQ_STAT_OFS, 32'h1F);
    sa <= 1'b0;
    ta <= 1'b0;
    repeat (5) @(negedge clk);
    chk({f2_n, f3_n, irq}, 32'h1);
    @(posedge clk);
    sa <= $urandom_range(1);
    ta <= 1'b1;
    repeat (4) @(negedge clk);
    chk({f2_n, f3_n}, {sa, 1'b1});
    @(posedge clk);
    sa <= 1'b1;
    apb(1'b1, srw_pkg::IRQ_STAT_OFS, 32'h8);
    apb(1'b0, srw_pkg::IRQ_STAT_OFS, 32'h0);
    chk({rd[4:0], irq}, 32'h9);
    apb(1'b1, srw_pkg::IRQ_STAT_OFS, 32'h4);
    repeat (3) @(negedge clk);
    chk(irq, 32'h0);
    @(posedge clk);
    mr_n <= 1'b0;
    repeat (20 + $urandom_range(30)) @(negedge clk);
    chk(sys_rst, 32'h1);
    @(posedge clk);
    mr_n <= 1'b1;
    meas(1'b0, n);
    chk(win(n, HC[3]), 32'h1);
    for (int i = 2; i >= 0; i--)
    begin
      m_ctrl = (m_ctrl & 32'h3) | (i << 2);
      apb(1'b1, srw_pkg::CTRL_OFS, m_ctrl);
      host.kick();
      meas(1'b1, n);
      chk(win(n, WC[i]), 32'h1);
      host.kick();
      repeat (12) @(negedge clk);
      chk(wdo_n, 32'h1);
    end
    apb(1'b1, srw_pkg::CTRL_OFS, m_ctrl | 32'hC);
    repeat (1100) @(negedge clk);
    chk(wdo_n, 32'h1);
    end_sim();
  end
endmodule : srw_top_tb
`default_nettype wire
